// ---- logic/psd_pkg.sv ----
// Purpose: shared constants for the serial-programmed synthesizer digital section
// Assumes: one 250 MHz system clock; latch fields laid out in a 21-bit word
// Notes: all widths, positions, codes and timing counts live here
package psd_pkg;

  localparam int WORD_W = 21;
  localparam int REF_W = 14;
  localparam int MAIN_W = 13;
  localparam int SWAL_W = 5;
  localparam int PRE_W = 6;
  localparam int ERR_W = 8;

  // control bits (low two bits of each word)
  localparam logic [1:0] SEL_REF = 2'h0;
  localparam logic [1:0] SEL_FB = 2'h1;
  localparam logic [1:0] SEL_FUNC = 2'h2;
  localparam logic [1:0] SEL_INIT = 2'h3;

  // reference divider latch
  localparam int REF_DIV_LSB = 2;
  localparam int TEST_LSB = 16;
  localparam int LOCK_PREC_BIT = 20;
  // feedback divider latch
  localparam int SWAL_LSB = 2;
  localparam int MAIN_LSB = 7;
  localparam int GAIN_BIT = 20;
  // function / initialization latch
  localparam int DIV_RST_BIT = 2;
  localparam int PD_LOW_BIT = 3;
  localparam int OSEL_LSB = 4;
  localparam int POL_BIT = 7;
  localparam int TRI_BIT = 8;
  localparam int FS_EN_BIT = 9;
  localparam int FS_MODE_BIT = 11;
  localparam int FS_TO_LSB = 12;
  localparam int PD_HIGH_BIT = 19;

  localparam logic [WORD_W-1:0] LATCH_RST = 21'h000000;

  // monitor output select codes
  localparam logic [2:0] MON_HIZ = 3'h0;
  localparam logic [2:0] MON_DLOCK = 3'h1;
  localparam logic [2:0] MON_FB_DIV = 3'h2;
  localparam logic [2:0] MON_HIGH = 3'h3;
  localparam logic [2:0] MON_REF_DIV = 3'h4;
  localparam logic [2:0] MON_ALOCK = 3'h5;
  localparam logic [2:0] MON_SDATA = 3'h6;
  localparam logic [2:0] MON_LOW = 3'h7;

  // prescaler modulus P (P/P+1)
  localparam int PRESCALE_HI = 32;
  localparam int PRESCALE_LO = 8;

  // lock detection timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int LOCK_ERR_NS = 15;
  localparam int UNLOCK_ERR_NS = 25;
  localparam logic [ERR_W-1:0] LOCK_MAX_CYC = ERR_W'(LOCK_ERR_NS / CLK_PERIOD_NS);
  localparam logic [ERR_W-1:0] UNLOCK_MAX_CYC = ERR_W'(UNLOCK_ERR_NS / CLK_PERIOD_NS);
  localparam logic [2:0] LOCK_RUN_SHORT = 3'h3;
  localparam logic [2:0] LOCK_RUN_LONG = 3'h5;

  // pin sync vector positions
  localparam int PIN_N = 6;
  localparam int P_SCLK = 0;
  localparam int P_SDATA = 1;
  localparam int P_LOAD = 2;
  localparam int P_REF = 3;
  localparam int P_RF = 4;
  localparam int P_CE = 5;

endpackage

// ---- logic/psd_fb_if.sv ----
// Purpose: carries feedback divider settings and its output between modules
// Assumes: all signals on sys_clk
// Notes: ctrl side owns settings, div side returns one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface psd_fb_if;
  import psd_pkg::*;
  logic rf_tick;
  logic hold;
  logic [SWAL_W-1:0] swallow_count;
  logic [MAIN_W-1:0] main_feedback_count;
  logic fb_pulse;

  modport ctrl (output rf_tick, output hold, output swallow_count,
                output main_feedback_count, input fb_pulse);
  modport div (input rf_tick, input hold, input swallow_count,
               input main_feedback_count, output fb_pulse);
endinterface
`default_nettype wire

// ---- logic/psd_fb_div.sv ----
// Purpose: dual-modulus prescaler with swallow and main counters
// Assumes: rf_tick is one pulse per RF input rising edge
// Notes: divides by P*main + swallow; main must not be below swallow
`timescale 1ns/1ps
`default_nettype none
module psd_fb_div
  import psd_pkg::*;
#(
  parameter int PRESCALE_P = PRESCALE_HI
) (
  input wire logic sys_clk, // system clock
  input wire logic rst_n, // async reset, active low
  psd_fb_if.div fb // settings in, pulse out
);

  localparam logic [PRE_W-1:0] TC_P = PRE_W'(PRESCALE_P - 1);
  localparam logic [PRE_W-1:0] TC_P1 = PRE_W'(PRESCALE_P);

  logic [PRE_W-1:0] pre_reg;
  logic [SWAL_W-1:0] swal_reg;
  logic [MAIN_W-1:0] main_reg;
  logic fb_reg;
  logic [PRE_W-1:0] pre_tc;

  // modulus P+1 while swallowing, P afterwards
  assign pre_tc = (swal_reg != '0) ? TC_P1 : TC_P;
  assign fb.fb_pulse = fb_reg;

  ////////////////////////////////////////////////////////////////////////
  // single counter stands in for the 4/5 core chain; same count per cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_reg <= '0;
      swal_reg <= '0;
      main_reg <= '0;
      fb_reg <= 1'b0;
    end else if (fb.hold) begin
      pre_reg <= '0;
      swal_reg <= fb.swallow_count;
      main_reg <= fb.main_feedback_count;
      fb_reg <= 1'b0;
    end else begin
      fb_reg <= 1'b0;
      if (fb.rf_tick) begin
        if (pre_reg == pre_tc) begin
          pre_reg <= '0;
          if (main_reg <= MAIN_W'(1)) begin
            swal_reg <= fb.swallow_count;
            main_reg <= fb.main_feedback_count;
            fb_reg <= 1'b1;
          end else begin
            main_reg <= main_reg - MAIN_W'(1);
            if (swal_reg != '0) begin
              swal_reg <= swal_reg - SWAL_W'(1);
            end
          end
        end else begin
          pre_reg <= pre_reg + PRE_W'(1);
        end
      end
    end
  end

endmodule
`default_nettype wire

// ---- logic/psd_top.sv ----
// Purpose: serial-programmed synthesizer digital section
// Assumes: all pins asynchronous to sys_clk and far slower than it
// Notes: pins pass three flops; a level counts once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - each serial clock rising edge shifts one data bit into 21-bit register.
// - load strobe rising edge copies shift register into one of four latches.
// - bits 1:0 pick latch: 00 ref, 01 feedback, 10 function, 11 init.
// - 14-bit reference divider divides reference input by 1 to 16383.
// - main feedback counter is 13 bits, ratios 3 to 8191.
// - swallow counter is 5 bits, values 0 to 31.
// - feedback ratio is P times main plus swallow; P+1 while swallowing.
// - prescaler pair 8/9 or 32/33 by parameter, counted per modulus.
// - digital lock rises after three cycles (five with lock precision bit set) with phase error under 15 ns.
// - digital lock falls when a later cycle shows error above 25 ns.
// - three output-select bits of function latch choose monitor source.
// - phase comparator compares reference and feedback pulses, drives pump.
// - open-drain lock mode pulls low only during phase error pulses.
// - feedback count totals 18 bits: 5 swallow plus 13 main.
// - chip enable low powers down and tristates the pump.
// - monitor can show lock, divided RF or divided reference.
module psd_top
  import psd_pkg::*;
#(
  parameter int PRESCALE_P = PRESCALE_HI
) (
  input wire logic sys_clk, // 250 MHz system clock
  input wire logic rst_n, // async reset, active low
  input wire logic serial_clock, // serial clock pin
  input wire logic serial_data, // serial data pin
  input wire logic load_strobe, // latch load pin
  input wire logic reference_input, // reference frequency pin
  input wire logic rf_input, // RF feedback pin, already squared
  input wire logic chip_enable, // chip enable pin, high runs
  output logic monitor_output, // monitor pin level
  output logic monitor_oe, // monitor pin drive enable
  output logic pump_up, // charge pump source pulse
  output logic pump_down, // charge pump sink pulse
  output logic pump_oe, // charge pump drive enable
  output logic pump_gain_high, // pump gain select
  output logic digital_lock // digital lock indication
);

  function automatic logic rise(input logic now_v, input logic was_v);
    return now_v & ~was_v;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] sync1_reg;
  logic [PIN_N-1:0] sync2_reg;
  logic [PIN_N-1:0] sync3_reg;
  logic [PIN_N-1:0] pin_reg;
  logic [PIN_N-1:0] pin_next;

  assign pin_raw = {chip_enable, rf_input, reference_input, load_strobe,
                    serial_data, serial_clock};

  always_comb begin
    for (int i = 0; i < PIN_N; i++) begin
      pin_next[i] = (sync2_reg[i] == sync3_reg[i]) ? sync3_reg[i] : pin_reg[i];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
      pin_reg <= '0;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      pin_reg <= pin_next;
    end
  end

  logic sclk_rise;
  logic load_rise;
  logic ref_tick;
  assign sclk_rise = rise(pin_next[P_SCLK], pin_reg[P_SCLK]);
  assign load_rise = rise(pin_next[P_LOAD], pin_reg[P_LOAD]);
  assign ref_tick = rise(pin_next[P_REF], pin_reg[P_REF]);

  ////////////////////////////////////////////////////////////////////////
  // shift register and latches
  logic [WORD_W-1:0] shift_reg;
  logic [WORD_W-1:0] ref_latch_reg;
  logic [WORD_W-1:0] fb_latch_reg;
  logic [WORD_W-1:0] func_latch_reg;
  logic init_pulse_reg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= LATCH_RST;
    end else if (sclk_rise) begin
      shift_reg <= {shift_reg[WORD_W-2:0], pin_reg[P_SDATA]};
    end
  end

  // init latch shares the function fields and also restarts the dividers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_latch_reg <= LATCH_RST;
      fb_latch_reg <= LATCH_RST;
      func_latch_reg <= LATCH_RST;
      init_pulse_reg <= 1'b0;
    end else begin
      init_pulse_reg <= 1'b0;
      if (load_rise) begin
        if (shift_reg[1:0] == SEL_REF) begin
          ref_latch_reg <= shift_reg;
        end else if (shift_reg[1:0] == SEL_FB) begin
          fb_latch_reg <= shift_reg;
        end else if (shift_reg[1:0] == SEL_FUNC) begin
          func_latch_reg <= shift_reg;
        end else begin
          func_latch_reg <= shift_reg;
          init_pulse_reg <= 1'b1;
        end
      end
    end
  end

  logic [REF_W-1:0] reference_divide_value;
  logic lock_precision_select;
  logic [2:0] output_select;
  logic powered_down;
  logic div_hold;
  logic comparator_polarity_bit;
  logic pump_tristate_bit;

  assign reference_divide_value = ref_latch_reg[REF_DIV_LSB +: REF_W];
  assign lock_precision_select = ref_latch_reg[LOCK_PREC_BIT];
  assign output_select = func_latch_reg[OSEL_LSB +: 3];
  assign comparator_polarity_bit = func_latch_reg[POL_BIT];
  assign pump_tristate_bit = func_latch_reg[TRI_BIT];
  assign powered_down = ~pin_reg[P_CE] | func_latch_reg[PD_LOW_BIT];
  assign div_hold = powered_down | func_latch_reg[DIV_RST_BIT] | init_pulse_reg;

  ////////////////////////////////////////////////////////////////////////
  // reference divider; a programmed zero behaves as one
  logic [REF_W-1:0] ref_cnt_reg;
  logic ref_pulse_reg;
  logic ref_tog_reg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_cnt_reg <= '0;
      ref_pulse_reg <= 1'b0;
      ref_tog_reg <= 1'b0;
    end else if (div_hold) begin
      ref_cnt_reg <= '0;
      ref_pulse_reg <= 1'b0;
    end else begin
      ref_pulse_reg <= 1'b0;
      if (ref_tick) begin
        if (ref_cnt_reg + REF_W'(1) >= reference_divide_value) begin
          ref_cnt_reg <= '0;
          ref_pulse_reg <= 1'b1;
          ref_tog_reg <= ~ref_tog_reg;
        end else begin
          ref_cnt_reg <= ref_cnt_reg + REF_W'(1);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // feedback divider
  psd_fb_if fb_bus ();
  assign fb_bus.rf_tick = rise(pin_next[P_RF], pin_reg[P_RF]);
  assign fb_bus.hold = div_hold;
  assign fb_bus.swallow_count = fb_latch_reg[SWAL_LSB +: SWAL_W];
  assign fb_bus.main_feedback_count = fb_latch_reg[MAIN_LSB +: MAIN_W];

  psd_fb_div #(
    .PRESCALE_P(PRESCALE_P)
  ) u_fb_div (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .fb(fb_bus.div)
  );

  logic fb_tog_reg;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fb_tog_reg <= 1'b0;
    end else if (fb_bus.fb_pulse) begin
      fb_tog_reg <= ~fb_tog_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // phase comparator: lead sets one side, both high clears both
  logic lead_ref_reg;
  logic lead_fb_reg;
  logic both_set;
  assign both_set = lead_ref_reg & lead_fb_reg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lead_ref_reg <= 1'b0;
      lead_fb_reg <= 1'b0;
    end else if (div_hold) begin
      lead_ref_reg <= 1'b0;
      lead_fb_reg <= 1'b0;
    end else begin
      lead_ref_reg <= (lead_ref_reg | ref_pulse_reg) & ~both_set;
      lead_fb_reg <= (lead_fb_reg | fb_bus.fb_pulse) & ~both_set;
    end
  end

  // polarity swaps pump direction for inverting loop filters
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pump_up <= 1'b0;
      pump_down <= 1'b0;
      pump_oe <= 1'b0;
      pump_gain_high <= 1'b0;
    end else begin
      pump_up <= comparator_polarity_bit ? lead_ref_reg : lead_fb_reg;
      pump_down <= comparator_polarity_bit ? lead_fb_reg : lead_ref_reg;
      pump_oe <= ~powered_down & ~pump_tristate_bit;
      pump_gain_high <= fb_latch_reg[GAIN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // error width measured in sys_clk cycles, judged when both sides clear
  logic err_active;
  logic err_was_reg;
  logic [ERR_W-1:0] err_cnt_reg;
  logic [2:0] good_run_reg;
  logic [2:0] run_need;

  assign err_active = lead_ref_reg | lead_fb_reg;
  assign run_need = lock_precision_select ? LOCK_RUN_LONG : LOCK_RUN_SHORT;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      err_was_reg <= 1'b0;
      err_cnt_reg <= '0;
    end else begin
      err_was_reg <= err_active;
      if (err_active) begin
        if (err_cnt_reg != '1) begin
          err_cnt_reg <= err_cnt_reg + ERR_W'(1);
        end
      end else begin
        err_cnt_reg <= '0;
      end
    end
  end

  // count saturates, so a stuck error still reads as above the limit
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      good_run_reg <= '0;
      digital_lock <= 1'b0;
    end else if (powered_down) begin
      good_run_reg <= '0;
      digital_lock <= 1'b0;
    end else if (err_was_reg && !err_active) begin
      if (err_cnt_reg <= LOCK_MAX_CYC) begin
        if (good_run_reg + 3'h1 >= run_need) begin
          digital_lock <= 1'b1;
        end else begin
          good_run_reg <= good_run_reg + 3'h1;
        end
      end else begin
        good_run_reg <= '0;
        if (err_cnt_reg > UNLOCK_MAX_CYC) begin
          digital_lock <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // monitor multiplexer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      monitor_output <= 1'b0;
      monitor_oe <= 1'b0;
    end else begin
      monitor_output <= 1'b0;
      monitor_oe <= 1'b1;
      case (output_select)
        MON_HIZ: begin
          monitor_oe <= 1'b0;
        end
        MON_DLOCK: begin
          monitor_output <= digital_lock;
        end
        MON_FB_DIV: begin
          monitor_output <= fb_tog_reg;
        end
        MON_HIGH: begin
          monitor_output <= 1'b1;
        end
        MON_REF_DIV: begin
          monitor_output <= ref_tog_reg;
        end
        MON_ALOCK: begin
          monitor_oe <= err_active;
        end
        MON_SDATA: begin
          monitor_output <= shift_reg[WORD_W-1];
        end
        default: begin
          monitor_output <= 1'b0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ---- dv/psd_top_chk.sv ----
// Purpose: port-level checks for the synthesizer digital section
// Assumes: sees only psd_top ports, one clock domain
// Notes: pump widths are counted in sys_clk cycles of up or down activity
`timescale 1ns/1ps
`default_nettype none
module psd_top_chk
  import psd_pkg::*;
#(
  parameter int PRESCALE_P = PRESCALE_HI
) (
  input wire logic sys_clk, // clock
  input wire logic rst_n, // async reset, active low
  input wire logic load_strobe, // load pin
  input wire logic chip_enable, // enable pin
  input wire logic pump_up, // pump source
  input wire logic pump_down, // pump sink
  input wire logic pump_oe, // pump drive enable
  input wire logic pump_gain_high, // gain bit
  input wire logic digital_lock // lock flag
);
  logic [7:0] run_len;
  logic [7:0] since_load;
  logic load_q;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  //////////////////////////////////////////////////////////////////////////////
  // saturating, so a stuck pump still reads as one long error
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_len <= 8'h00;
    end else if (pump_up || pump_down) begin
      run_len <= (run_len == 8'hFF) ? run_len : run_len + 8'h01;
    end else begin
      run_len <= 8'h00;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      load_q <= 1'b0;
      since_load <= 8'hFF;
    end else begin
      load_q <= load_strobe;
      if (load_strobe && !load_q) begin
        since_load <= 8'h00;
      end else if (since_load != 8'hFF) begin
        since_load <= since_load + 8'h01;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  property p_ce_tristate;
    !chip_enable [*6] |-> !pump_oe;
  endproperty
  a_ce_tristate: assert property (p_ce_tristate)
    else $error("pump still driven in power down");
  property p_ce_unlock;
    !chip_enable [*6] |-> !digital_lock;
  endproperty
  a_ce_unlock: assert property (p_ce_unlock)
    else $error("lock held in power down");
  property p_ce_quiet;
    !chip_enable [*8] |-> !pump_up && !pump_down;
  endproperty
  a_ce_quiet: assert property (p_ce_quiet)
    else $error("pump pulses in power down");
  property p_bad_unlock;
    run_len == 8'd7 |-> ##[1:400] !digital_lock;
  endproperty
  a_bad_unlock: assert property (p_bad_unlock)
    else $error("lock kept after wide phase error");
  property p_rise_clean;
    $rose(digital_lock) |-> run_len < 8'd7;
  endproperty
  a_rise_clean: assert property (p_rise_clean)
    else $error("lock rose during wide phase error");
  property p_rise_powered;
    $rose(digital_lock) |-> $past(chip_enable, 6);
  endproperty
  a_rise_powered: assert property (p_rise_powered)
    else $error("lock rose out of power down");
  property p_pump_excl;
    pump_up && pump_down |=> !(pump_up && pump_down);
  endproperty
  a_pump_excl: assert property (p_pump_excl)
    else $error("pump up and down held together");
  property p_gain_on_load;
    $changed(pump_gain_high) |-> since_load < 8'd12;
  endproperty
  a_gain_on_load: assert property (p_gain_on_load)
    else $error("gain changed without a load");
endmodule

bind psd_top psd_top_chk #(.PRESCALE_P(PRESCALE_P)) chk (
  .sys_clk(sys_clk),
  .rst_n(rst_n),
  .load_strobe(load_strobe),
  .chip_enable(chip_enable),
  .pump_up(pump_up),
  .pump_down(pump_down),
  .pump_oe(pump_oe),
  .pump_gain_high(pump_gain_high),
  .digital_lock(digital_lock)
);
`default_nettype wire

// ---- dv/psd_host.sv ----
// Purpose: host side of the 3-wire serial link
// Assumes: pins are sampled through sync flops, so levels last many cycles
// Notes: data line shows garbage once its hold time is over
`timescale 1ns/1ps
`default_nettype none
module psd_host (
  input wire logic sys_clk, // system clock
  output logic serial_clock, // serial clock pin
  output logic serial_data, // serial data pin
  output logic load_strobe // load pin
);
  initial begin
    serial_clock = 1'b0;
    serial_data = 1'b0;
    load_strobe = 1'b0;
  end

  task automatic pulse_load();
    repeat (4) @(posedge sys_clk);
    load_strobe <= 1'b1;
    repeat (6) @(posedge sys_clk);
    load_strobe <= 1'b0;
    repeat (6) @(posedge sys_clk);
  endtask

  task automatic send(input logic [20:0] w, input logic ld);
    for (int i = 20; i >= 0; i--) begin
      @(posedge sys_clk);
      serial_data <= w[i];
      repeat (5) @(posedge sys_clk);
      serial_clock <= 1'b1;
      repeat (5) @(posedge sys_clk);
      serial_clock <= 1'b0;
      repeat (5) @(posedge sys_clk);
      serial_data <= ~w[i];
    end
    if (ld) begin
      pulse_load();
    end
  endtask
endmodule
`default_nettype wire

// ---- dv/test_psd_top.sv ----
// Purpose: self-checking bench for psd_top
// Assumes: prescaler 8; reference and RF pins share one wave
// Notes: equal ref and feedback ratios give zero phase error
`timescale 1ns/1ps
`default_nettype none
module test_psd_top;
  import psd_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic chip_enable = 1'b1;
  logic [2:0] ph = 3'h0;
  wire logic sclk;
  wire logic sdata;
  wire logic load;
  logic mon, mon_oe, pup, pdn, poe, gain, lock;
  int errors = 0;
  int n_tests = 0;
  int n;
  logic m;
  logic [2:0] codes [3] = '{3'h3, 3'h7, 3'h0};
  logic exp_out [3] = '{1'b1, 1'b0, 1'b0};
  logic exp_oe [3] = '{1'b1, 1'b1, 1'b0};

  always #2 sys_clk = ~sys_clk;
  // one wave feeds both dividers, period 8 cycles
  always @(posedge sys_clk) ph <= ph + 3'h1;

  psd_host host (.sys_clk(sys_clk), .serial_clock(sclk), .serial_data(sdata),
                 .load_strobe(load));
  psd_top #(.PRESCALE_P(PRESCALE_LO)) uut (
    .sys_clk(sys_clk), .rst_n(rst_n), .serial_clock(sclk), .serial_data(sdata),
    .load_strobe(load), .reference_input(ph[2]), .rf_input(ph[2]),
    .chip_enable(chip_enable), .monitor_output(mon), .monitor_oe(mon_oe),
    .pump_up(pup), .pump_down(pdn), .pump_oe(poe), .pump_gain_high(gain),
    .digital_lock(lock));

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic seen, input logic exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %b seen %b", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic wr(input logic [20:0] w);
    host.send(w, 1'b1);
    repeat (10) @(negedge sys_clk);
  endtask

  task automatic wait_lock(input logic want, output int cnt);
    cnt = 0;
    while (lock !== want && cnt < 3000) begin
      @(negedge sys_clk);
      cnt++;
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (6) @(negedge sys_clk);
    check("lock", lock, 1'b0);
    check("gain", gain, 1'b0);
    check("mon_oe", mon_oe, 1'b0);
    wr(21'h100181);
    check("gain", gain, 1'b1);
    wr(21'h000060);
    check("gain", gain, 1'b1);
    wr(21'h000013);
    check("mon_oe", mon_oe, 1'b1);
    wait_lock(1'b1, n);
    check("lock", lock, 1'b1);
    check("lock_fast", n < 700, 1'b1);
    // monitor is registered one cycle behind the lock flag
    repeat (2) @(negedge sys_clk);
    check("mon", mon, 1'b1);
    check("pump_oe", poe, 1'b1);
    wr(21'h000064);
    wait_lock(1'b0, n);
    check("unlock", lock, 1'b0);
    // main 5, swallow 3: three cycles of 9 plus two of 8 is 43, matched by ref 43
    wr(21'h10028D);
    wr(21'h1000AC);
    // power-down bit clears any good run left from the drifting phase
    wr(21'h00001A);
    check("pd_bit_pump_oe", poe, 1'b0);
    wr(21'h000013);
    wait_lock(1'b1, n);
    check("lock_swallow", lock, 1'b1);
    check("lock_slow", n > 1000, 1'b1);
    @(posedge sys_clk);
    chip_enable <= 1'b0;
    repeat (12) @(negedge sys_clk);
    check("pd_pump_oe", poe, 1'b0);
    check("pd_lock", lock, 1'b0);
    @(posedge sys_clk);
    chip_enable <= 1'b1;
    repeat (12) @(negedge sys_clk);
    check("pu_pump_oe", poe, 1'b1);
    for (int i = 0; i < 3; i++) begin
      wr({14'h0, codes[i], 4'h2});
      if (codes[i] != 3'h0)
        check("mon_sel", mon, exp_out[i]);
      check("mon_sel_oe", mon_oe, exp_oe[i]);
    end
    for (int c = 2; c <= 4; c += 2) begin
      wr({14'h0, 3'(c), 4'h2});
      m = mon;
      n = 0;
      while (mon === m && n < 600) begin
        @(negedge sys_clk);
        n++;
      end
      check("mon_div", mon !== m, 1'b1);
    end
    // open-drain lock: pin only driven low during the one-cycle error pulses
    wr(21'h000052);
    n = 0;
    m = 1'b0;
    repeat (700) begin
      @(negedge sys_clk);
      if (mon_oe === 1'b1)
        n++;
      if (mon !== 1'b0)
        m = 1'b1;
    end
    check("alock_low", m, 1'b0);
    check("alock_pulses", n >= 1 && n <= 3, 1'b1);
    wr(21'h000062);
    host.send(21'h100000, 1'b0);
    repeat (8) @(negedge sys_clk);
    check("shift_msb", mon, 1'b1);
    host.send(21'h000181, 1'b0);
    repeat (8) @(negedge sys_clk);
    check("shift_msb", mon, 1'b0);
    check("gain_noload", gain, 1'b1);
    host.pulse_load();
    repeat (10) @(negedge sys_clk);
    check("gain_load", gain, 1'b0);
    conclude();
  end

  initial begin
    repeat (60000) @(posedge sys_clk);
    errors++;
    $display("BAD watchdog expected finish seen hang");
    conclude();
  end
endmodule
`default_nettype wire
